// file: rtl/hsp_pkg.sv
// shared constants and types for the host serial port
`default_nettype none
package hsp_pkg;
  // clocks and link rate
  localparam int REF_CLK_MHZ = 125;
  localparam int LINK_CLK_HZ = 166_666_667;
  localparam int BAUD_HZ = 3_000_000;
  localparam int BIT_CYC = LINK_CLK_HZ / BAUD_HZ;
  // attention lead before a message and release gap after it
  localparam int ATTN_LEAD_NS = 1000;
  localparam int ATTN_GAP_NS = 1000;
  localparam int ATTN_LEAD_CYC = (ATTN_LEAD_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int ATTN_GAP_CYC = (ATTN_GAP_NS * REF_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] LEAD_CNT = 8'(ATTN_LEAD_CYC);
  localparam logic [7:0] GAP_CNT = 8'(ATTN_GAP_CYC);
  localparam logic [7:0] SETTLE_CNT = 8'h03;
  // two-wire target address and byte framing
  localparam logic [5:0] ADDR_HI = 6'h25;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // serial character: index 0 start, 1..8 data, 9 stop
  localparam logic [3:0] DATA_END_IDX = 4'h8;
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [7:0] FRAME_BYTE = 8'h7E;

  // interface chosen by the straps, fixed until the next reset
  typedef struct packed {
    logic i2c_on;
    logic uart_on;
    logic loader_on;
  } mode_t;

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_LOAD, I_RD, I_RACK, I_SKIP
  } i2c_st_t;

  typedef enum logic [2:0] {
    U_IDLE, U_LEAD, U_HEAD, U_BODY, U_TAIL, U_DRAIN, U_GAP
  } u_st_t;
endpackage
`default_nettype wire

// file: rtl/host_serial_port.sv
// host serial port: two-wire bus target and framed async serial link
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - act as two-wire bus target at standard and fast speed
// - answer address 100101 plus address-select pin as lowest bit
// - address-select pin captured only at reset; board holds it fixed
// - start is data fall with clock high, stop is data rise
// - bytes are eight bits, msb first, data changes while clock low
// - multi-byte values go least significant byte first
// - receiver acknowledges each byte by pulling data low on ninth clock
// - device may stretch the clock low; host waits for release
// - first byte holds address and direction bit; zero means write
// - on host write, acknowledge matching address and every data byte
// - on host read, drive data right after address acknowledge
// - repeated start is not supported
// - attention output is active low
// - loader-select sampled at reset; low selects firmware loader
// - serial link runs 3 Mbit/s, 8 data bits, no parity, one stop
// - line idles high; low start bit, data lsb first, high stop
// - device sends its characters back to back
// - serial mode: attention low before each message, released between
// - each serial transmission is wrapped in framing bytes
// - all straps captured at reset and held until the next reset
module host_serial_port #(
  parameter logic [7:0] BIT_CYC_P = 8'(hsp_pkg::BIT_CYC)
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic uart_rx,
  output logic uart_tx,
  input wire logic addr_lsb_pin,
  input wire logic proto_sel_hi,
  input wire logic proto_sel_lo_wake,
  input wire logic loader_select_n,
  output logic host_attention_n,
  input wire logic attn_req,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output var hsp_pkg::mode_t mode
);
  import hsp_pkg::*;

  logic rst_m, rst_n;
  logic [5:0] pin_m, pin_s;
  logic scl_d, sda_d, scl_s, sda_s;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic strap_done_r;
  logic [6:0] own_addr_r;
  logic addr_hit;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_m <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_m <= 1'h1;
      rst_n <= rst_m;
    end
  end

  // pin synchronisers run during reset so straps are settled at release
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      pin_m <= {scl_in, sda_in, loader_select_n, proto_sel_hi,
                proto_sel_lo_wake, addr_lsb_pin};
      pin_s <= pin_m;
      scl_d <= pin_s[5];
      sda_d <= pin_s[4];
    end
  end

  assign scl_s = pin_s[5];
  assign sda_s = pin_s[4];

  // bus conditions seen on the synchronised lines
  assign scl_rise = clk_en && scl_s && !scl_d;
  assign scl_fall = clk_en && !scl_s && scl_d;
  assign start_det = clk_en && scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = clk_en && scl_s && scl_d && !sda_d && sda_s;

  // straps are taken once, at the first enabled cycle after release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'h0;
      own_addr_r <= 7'h00;
      mode <= '0;
    end else if (clk_en && !strap_done_r) begin
      strap_done_r <= 1'h1;
      own_addr_r <= {ADDR_HI, pin_s[0]};
      mode.i2c_on <= !pin_s[2] && !pin_s[1];
      mode.uart_on <= pin_s[2] && !pin_s[1];
      mode.loader_on <= !pin_s[3];
    end
  end

  chk_strap_frozen:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      strap_done_r && $past(strap_done_r) |->
        $stable(own_addr_r) && $stable(mode))
    else $error("strap value changed after capture");

  // byte holder fed by the user; drained by a bus read or the serial link
  logic [7:0] hold_r;
  logic hold_full_r, hold_last_r, hold_full_nxt;
  logic take, i2c_take, u_take;

  assign take = clk_en && tx_valid && tx_ready;
  assign hold_full_nxt = (hold_full_r || take) && !(i2c_take || u_take);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 8'h00;
      hold_last_r <= 1'h0;
      hold_full_r <= 1'h0;
      tx_ready <= 1'h0;
    end else if (clk_en) begin
      if (take) begin
        hold_r <= tx_data;
        hold_last_r <= tx_last;
      end
      hold_full_r <= hold_full_nxt;
      tx_ready <= !hold_full_nxt;
    end
  end

  // two-wire target state machine
  i2c_st_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic sdo_nxt, slo_nxt, i2c_rx;

  assign addr_hit = sh_r[7:1] == own_addr_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    sdo_nxt = sda_oe;
    slo_nxt = scl_oe;
    i2c_rx = 1'h0;
    i2c_take = 1'h0;
    if (!mode.i2c_on) begin
      st_nxt = I_IDLE;
    end else if (start_det) begin
      // a start inside a transfer is a repeated start: sit it out
      st_nxt = (st_r == I_IDLE) ? I_ADDR : I_SKIP;
      cnt_nxt = 4'h0;
      sdo_nxt = 1'h0;
      slo_nxt = 1'h0;
    end else if (stop_det) begin
      st_nxt = I_IDLE;
      sdo_nxt = 1'h0;
      slo_nxt = 1'h0;
    end else begin
      case (st_r)
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            if (st_r == I_WR) begin
              sdo_nxt = 1'h1;
              i2c_rx = 1'h1;
              st_nxt = I_WACK;
            end else if (addr_hit) begin
              sdo_nxt = 1'h1;
              st_nxt = I_AACK;
            end else begin
              st_nxt = I_SKIP;
            end
          end
        end
        I_AACK: begin
          if (scl_fall) begin
            sdo_nxt = 1'h0;
            cnt_nxt = 4'h0;
            st_nxt = sh_r[0] ? I_LOAD : I_WR;
          end
        end
        I_WACK: begin
          if (scl_fall) begin
            sdo_nxt = 1'h0;
            cnt_nxt = 4'h0;
            st_nxt = I_WR;
          end
        end
        I_LOAD: begin
          if (hold_full_r) begin
            sh_nxt = hold_r;
            i2c_take = 1'h1;
            sdo_nxt = !hold_r[7];
            cnt_nxt = 4'h0;
            st_nxt = I_RD;
          end else begin
            slo_nxt = 1'h1;
          end
        end
        I_RD: begin
          // clock freed a cycle after data is set, so data never moves high
          slo_nxt = 1'h0;
          if (scl_fall) begin
            if (cnt_r == LAST_BIT) begin
              sdo_nxt = 1'h0;
              st_nxt = I_RACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'h0};
              sdo_nxt = !sh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        I_RACK: begin
          // a nack ends the read; the line is already released
          if (scl_rise && sda_s) begin
            st_nxt = I_IDLE;
          end else if (scl_fall) begin
            st_nxt = I_LOAD;
          end
        end
        default: begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  // open-drain drivers only ever pull low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= I_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      sda_oe <= 1'h0;
      scl_oe <= 1'h0;
      sda_out <= 1'h0;
      scl_out <= 1'h0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      sda_oe <= sdo_nxt;
      scl_oe <= slo_nxt;
    end
  end

  chk_addr_match:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == I_AACK |-> addr_hit && sda_oe)
    else $error("acknowledge given to a foreign address");

  chk_ack_low:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == I_WACK |-> sda_oe && !scl_oe)
    else $error("written byte not acknowledged");

  chk_nack_release:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == I_RACK && scl_rise && sda_s && mode.i2c_on |=>
        st_r == I_IDLE && !sda_oe)
    else $error("read not ended by host nack");

  chk_stop_idle:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      stop_det && mode.i2c_on |=> st_r == I_IDLE && !scl_oe && !sda_oe)
    else $error("stop did not free the bus");

  chk_restart_skip:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      start_det && mode.i2c_on && st_r != I_IDLE |=> st_r == I_SKIP)
    else $error("repeated start was accepted");

  chk_stretch_cause:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(scl_oe) |-> st_r == I_LOAD && !$past(hold_full_r))
    else $error("clock held low with data ready");

  // crossings between the two clocks
  logic req_r, ack_r, ack_m, ack_s, busy_m, busy_s, pend;
  logic rtg_m, rtg_s, rtg_d, rx_tgl_r, tx_busy_r;
  logic [7:0] tx_byte_r, rx_buf_r;

  assign pend = req_r != ack_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ack_m, ack_s, busy_m, busy_s} <= 4'h0;
      {rtg_m, rtg_s, rtg_d} <= 3'h0;
    end else if (clk_en) begin
      ack_m <= ack_r;
      ack_s <= ack_m;
      busy_m <= tx_busy_r;
      busy_s <= busy_m;
      rtg_m <= rx_tgl_r;
      rtg_s <= rtg_m;
      rtg_d <= rtg_s;
    end
  end

  // received bytes: from a bus write or, via toggle, from the serial link
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data <= 8'h00;
      rx_valid <= 1'h0;
    end else if (clk_en) begin
      rx_valid <= i2c_rx || (rtg_s != rtg_d);
      if (i2c_rx) begin
        rx_data <= sh_r;
      end else if (rtg_s != rtg_d) begin
        rx_data <= rx_buf_r;
      end
    end
  end

  chk_rx_pulse:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == I_WR ##1 st_r == I_WACK |-> rx_valid && rx_data == sh_r)
    else $error("written byte not delivered");

  // serial message sequencer: attention, frame, payload, frame, release
  u_st_t u_st_r, u_st_nxt;
  logic [7:0] u_cnt_r, u_cnt_nxt, u_byte;
  logic u_send, attn_nxt;

  always_comb begin
    u_st_nxt = u_st_r;
    u_cnt_nxt = (u_cnt_r == 8'h00) ? 8'h00 : u_cnt_r - 8'h01;
    u_send = 1'h0;
    u_take = 1'h0;
    u_byte = hold_r;
    case (u_st_r)
      U_IDLE: begin
        if (mode.uart_on && hold_full_r) begin
          u_st_nxt = U_LEAD;
          u_cnt_nxt = LEAD_CNT;
        end
      end
      U_LEAD: begin
        if (u_cnt_r == 8'h00) begin
          u_st_nxt = U_HEAD;
        end
      end
      U_HEAD: begin
        if (!pend) begin
          u_send = 1'h1;
          u_byte = FRAME_BYTE;
          u_st_nxt = U_BODY;
        end
      end
      U_BODY: begin
        if (!pend && hold_full_r) begin
          u_send = 1'h1;
          u_take = 1'h1;
          u_st_nxt = hold_last_r ? U_TAIL : U_BODY;
        end
      end
      U_TAIL: begin
        if (!pend) begin
          u_send = 1'h1;
          u_byte = FRAME_BYTE;
          u_st_nxt = U_DRAIN;
          u_cnt_nxt = SETTLE_CNT;
        end
      end
      U_DRAIN: begin
        // busy and ack cross separately, so let both settle first
        if (pend) begin
          u_cnt_nxt = SETTLE_CNT;
        end else if (!busy_s && u_cnt_r == 8'h00) begin
          u_st_nxt = U_GAP;
          u_cnt_nxt = GAP_CNT;
        end
      end
      U_GAP: begin
        if (u_cnt_r == 8'h00) begin
          u_st_nxt = U_IDLE;
        end
      end
      default: begin
        u_st_nxt = U_IDLE;
      end
    endcase
  end

  // attention: message window in serial mode, user request in two-wire mode
  assign attn_nxt = mode.uart_on ?
    (u_st_nxt != U_IDLE && u_st_nxt != U_GAP) :
    (mode.i2c_on && attn_req);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      u_st_r <= U_IDLE;
      u_cnt_r <= 8'h00;
      req_r <= 1'h0;
      tx_byte_r <= 8'h00;
      host_attention_n <= 1'h1;
    end else if (clk_en) begin
      u_st_r <= u_st_nxt;
      u_cnt_r <= u_cnt_nxt;
      host_attention_n <= !attn_nxt;
      if (u_send) begin
        req_r <= !req_r;
        tx_byte_r <= u_byte;
      end
    end
  end

  sequence s_msg_open;
    u_st_r == U_IDLE ##1 u_st_r == U_LEAD;
  endsequence

  sequence s_msg_close;
    u_st_r == U_DRAIN ##1 u_st_r == U_GAP;
  endsequence

  chk_attn_lead:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_msg_open |-> (!host_attention_n)[*2])
    else $error("attention not low before message");

  chk_attn_gap:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_msg_close |-> host_attention_n)
    else $error("attention not released between messages");

  // link clock domain: its own reset and enable copies
  logic lrst_m, lrst_n, lce_m, lce, lreq_m, lreq_s, tx_pend_l, tx_tick;
  logic [3:0] tx_bit_r, rx_bit_r;
  logic [7:0] tx_div_r, tx_sh_r, rx_div_r, rx_sh_r;
  logic rx_m, rx_s, rx_d, rx_act_r, rx_tick;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      {lrst_m, lrst_n} <= 2'h0;
    end else begin
      lrst_m <= 1'h1;
      lrst_n <= lrst_m;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {lce_m, lce, lreq_m, lreq_s} <= 4'h0;
      {rx_m, rx_s, rx_d} <= 3'h7;
    end else begin
      lce_m <= clk_en;
      lce <= lce_m;
      if (lce) begin
        lreq_m <= req_r;
        lreq_s <= lreq_m;
        rx_m <= uart_rx;
        rx_s <= rx_m;
        rx_d <= rx_s;
      end
    end
  end

  assign tx_pend_l = lreq_s != ack_r;
  assign tx_tick = tx_div_r == 8'h00;

  // transmitter; next character loads at the end of the stop bit
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      uart_tx <= 1'h1;
      tx_busy_r <= 1'h0;
      ack_r <= 1'h0;
      tx_div_r <= 8'h00;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 8'h00;
    end else if (lce) begin
      if (!tx_busy_r || (tx_tick && tx_bit_r == STOP_IDX)) begin
        if (tx_pend_l) begin
          tx_sh_r <= tx_byte_r;
          ack_r <= lreq_s;
          tx_busy_r <= 1'h1;
          tx_bit_r <= 4'h0;
          tx_div_r <= BIT_CYC_P - 8'h01;
          uart_tx <= 1'h0;
        end else begin
          tx_busy_r <= 1'h0;
          uart_tx <= 1'h1;
        end
      end else if (tx_tick) begin
        tx_div_r <= BIT_CYC_P - 8'h01;
        tx_bit_r <= tx_bit_r + 4'h1;
        if (tx_bit_r == DATA_END_IDX) begin
          uart_tx <= 1'h1;
        end else begin
          uart_tx <= tx_sh_r[0];
          tx_sh_r <= {1'h0, tx_sh_r[7:1]};
        end
      end else begin
        tx_div_r <= tx_div_r - 8'h01;
      end
    end
  end

  chk_line_idle:
    assert property (@(posedge link_clk) disable iff (!lrst_n)
      !tx_busy_r || tx_bit_r == STOP_IDX |-> uart_tx)
    else $error("serial line low outside a character");

  chk_back2back:
    assert property (@(posedge link_clk) disable iff (!lrst_n)
      lce && tx_busy_r && tx_tick && tx_bit_r == STOP_IDX && tx_pend_l
        |=> tx_busy_r && !uart_tx && tx_bit_r == 4'h0)
    else $error("gap inserted between characters");

  assign rx_tick = rx_div_r == 8'h00;

  // receiver samples mid-bit; a short start pulse is dropped
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      rx_act_r <= 1'h0;
      rx_bit_r <= 4'h0;
      rx_div_r <= 8'h00;
      rx_sh_r <= 8'h00;
      rx_buf_r <= 8'h00;
      rx_tgl_r <= 1'h0;
    end else if (lce) begin
      if (!rx_act_r) begin
        if (rx_d && !rx_s) begin
          rx_act_r <= 1'h1;
          rx_bit_r <= 4'h0;
          rx_div_r <= {1'h0, BIT_CYC_P[7:1]};
        end
      end else if (rx_tick) begin
        rx_div_r <= BIT_CYC_P - 8'h01;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          rx_act_r <= !rx_s;
        end else if (rx_bit_r == STOP_IDX) begin
          rx_act_r <= 1'h0;
          if (rx_s) begin
            rx_buf_r <= rx_sh_r;
            rx_tgl_r <= !rx_tgl_r;
          end
        end else begin
          rx_sh_r <= {rx_s, rx_sh_r[7:1]};
        end
      end else begin
        rx_div_r <= rx_div_r - 8'h01;
      end
    end
  end

endmodule // host_serial_port
`default_nettype wire

// file: bench/host_mcu_model.sv
// host microcontroller model: two-wire bus master and serial link partner
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic uart_tx,
  output logic scl_in,
  output logic sda_in,
  output var logic uart_rx
);
  localparam int Q = 625; // quarter of a 400 kHz bit
  localparam int UB = 330; // one link bit, 55 cycles of 6 ns
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  initial uart_rx = 1'b1;
  // open-drain wires with pull-ups: released means high, never a stale value
  assign scl_in = !(scl_low | scl_oe);
  assign sda_in = !(sda_low | sda_oe);

  // release the clock, then wait while the target stretches it
  task automatic rel_scl();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl_in !== 1'b1 && n < 40000) begin
      #1;
      n++;
    end
  endtask

  // one clock: data set while low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q;
    rel_scl();
    #Q;
    r = sda_in;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask

  // eight bits msb first, then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic ak_in,
                      output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ak_in, ak);
  endtask

  task automatic start();
    sda_low = 1'b0;
    rel_scl();
    #Q;
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #Q;
    rel_scl();
    #Q;
    sda_low = 1'b0;
    #(4 * Q);
  endtask

  // serial send keeps the host's minimum spacing after each character
  task automatic uart_send(input logic [7:0] d);
    uart_rx = 1'b0;
    #UB;
    for (int i = 0; i < 8; i++) begin
      uart_rx = d[i];
      #UB;
    end
    uart_rx = 1'b1;
    #(UB + 100_000);
  endtask

  // serial receive sampled mid-bit; returns byte, stop level, start time
  task automatic uart_get(output logic [7:0] d, output logic sb,
                          output realtime t0);
    int n;
    n = 0;
    while (uart_tx !== 1'b0 && n < 100_000) begin
      #1;
      n++;
    end
    t0 = $realtime;
    #(UB / 2 + UB);
    for (int i = 0; i < 8; i++) begin
      d[i] = uart_tx;
      #UB;
    end
    sb = uart_tx;
  endtask
endmodule // host_mcu_model
`default_nettype wire

// file: bench/test_host_serial_port.sv
// self-checking bench for the host serial port
`timescale 1ns/1ps
`default_nettype none
module test_host_serial_port;
  import hsp_pkg::*;
  typedef struct packed {
    logic hi;
    logic lo;
    logic ldr_n;
    logic [2:0] m;
  } row_t;
  // straps beside the mode they must select
  localparam row_t ROWS [6] = '{6'h0C, 6'h2A, 6'h05, 6'h23, 6'h38, 6'h18};
  logic ref_clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic scl_in, scl_oe, sda_in, sda_oe, uart_rx, uart_tx, tx_ready;
  logic scl_out, sda_out;
  logic addr_lsb_pin = 1'b0, proto_sel_hi = 1'b0, proto_sel_lo_wake = 1'b0;
  logic loader_select_n = 1'b1, attn_req = 1'b0, host_attention_n;
  logic tx_last = 1'b0, tx_valid = 1'b0, rx_valid, ak, sb;
  logic [7:0] tx_data = 8'h00, rx_data, got_rx, b;
  mode_t mode;
  int failures = 0, checked = 0, cyc = 0;
  realtime t0, t1;

  initial forever #4 ref_clk = !ref_clk;
  // link clock unrelated in phase to the main clock
  initial begin
    #1.7;
    forever #3 link_clk = !link_clk;
  end

  host_serial_port u_host_serial_port (
    .ref_clk, .reset_n, .clk_en, .link_clk, .scl_in, .scl_out, .scl_oe,
    .sda_in, .sda_out, .sda_oe, .uart_rx, .uart_tx, .addr_lsb_pin,
    .proto_sel_hi, .proto_sel_lo_wake, .loader_select_n, .host_attention_n,
    .attn_req, .tx_data, .tx_last, .tx_valid, .tx_ready, .rx_data,
    .rx_valid, .mode
  );
  host_mcu_model u_host_mcu_model (
    .scl_oe, .sda_oe, .uart_tx, .scl_in, .sda_in, .uart_rx
  );

  // hang guard, well beyond the expected run of about 50k cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90_000) begin
      failures++;
      end_of_test();
    end
  end
  // the received-byte pulse lasts one cycle, so catch it as it passes
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) got_rx = rx_data;
  end

  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic hi, input logic lo, input logic ldr_n);
    @(negedge ref_clk);
    reset_n = 1'b0;
    proto_sel_hi = hi;
    proto_sel_lo_wake = lo;
    loader_select_n = ldr_n;
    repeat (8) @(negedge ref_clk);
    chk_byte({5'h00, mode}, 8'h00);
    chk_bit(uart_tx, 1'b1);
    chk_bit(host_attention_n, 1'b1);
    chk_bit(sda_oe | scl_oe, 1'b0);
    chk_bit(sda_out | scl_out, 1'b0);
    reset_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
  // offer one byte and hold it until the port takes it
  task automatic offer(input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(negedge ref_clk);
    tx_data = d;
    tx_last = l;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask
  task automatic i2c_addr(input logic [7:0] a, input logic e);
    u_host_mcu_model.start();
    u_host_mcu_model.xfer(a, 1'b1, b, ak);
    chk_bit(ak, e);
  endtask

  initial begin
    // six of the eight strap choices, then straps moved after reset must not matter
    for (int i = 0; i < 6; i++) begin
      do_reset(ROWS[i].hi, ROWS[i].lo, ROWS[i].ldr_n);
      chk_byte({5'h00, mode}, {5'h00, ROWS[i].m});
      proto_sel_hi = !ROWS[i].hi;
      proto_sel_lo_wake = !ROWS[i].lo;
      loader_select_n = !ROWS[i].ldr_n;
      repeat (4) @(negedge ref_clk);
      chk_byte({5'h00, mode}, {5'h00, ROWS[i].m});
    end
    // two-wire mode with the address pin high
    addr_lsb_pin = 1'b1;
    do_reset(1'b0, 1'b0, 1'b1);
    attn_req = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk_bit(host_attention_n, 1'b0);
    attn_req = 1'b0;
    i2c_addr({ADDR_HI, 2'b10}, 1'b0);
    u_host_mcu_model.xfer(8'hB4, 1'b1, b, ak);
    chk_bit(ak, 1'b0);
    chk_byte(got_rx, 8'hB4);
    u_host_mcu_model.xfer(8'h61, 1'b1, b, ak);
    chk_byte(got_rx, 8'h61);
    i2c_addr({ADDR_HI, 2'b10}, 1'b1);
    u_host_mcu_model.stop();
    i2c_addr({ADDR_HI, 2'b00}, 1'b1);
    u_host_mcu_model.stop();
    i2c_addr({6'h24, 2'b10}, 1'b1);
    u_host_mcu_model.stop();
    // read with nothing offered yet: the clock must be held low
    i2c_addr({ADDR_HI, 2'b11}, 1'b0);
    repeat (40) @(negedge ref_clk);
    chk_bit(scl_oe, 1'b1);
    fork
      offer(8'hC6, 1'b0);
      u_host_mcu_model.xfer(8'hFF, 1'b1, b, ak);
    join
    chk_byte(b, 8'hC6);
    u_host_mcu_model.stop();
    chk_bit(sda_oe, 1'b0);
    // serial mode: one framed message out, then characters in
    do_reset(1'b1, 1'b0, 1'b1);
    fork
      begin
        offer(8'h11, 1'b0);
        offer(8'h22, 1'b1);
      end
      begin
        u_host_mcu_model.uart_get(b, sb, t0);
        chk_bit(host_attention_n, 1'b0);
        chk_byte(b, FRAME_BYTE);
        u_host_mcu_model.uart_get(b, sb, t1);
        chk_byte(b, 8'h11);
        chk_bit(sb, 1'b1);
        chk_bit(t1 - t0 < 3400.0, 1'b1);
        u_host_mcu_model.uart_get(b, sb, t0);
        chk_byte(b, 8'h22);
        u_host_mcu_model.uart_get(b, sb, t0);
        chk_byte(b, FRAME_BYTE);
      end
    join
    repeat (40) @(negedge ref_clk);
    chk_bit(host_attention_n, 1'b1);
    u_host_mcu_model.uart_send(8'h1D);
    chk_byte(got_rx, 8'h1D);
    u_host_mcu_model.uart_send(8'hE4);
    chk_byte(got_rx, 8'hE4);
    end_of_test();
  end
endmodule // test_host_serial_port
`default_nettype wire
